// *** hw/pas_pkg.sv ***
// constants shared by the pwm auto-shutdown block
package pas_pkg;

    // ==========================================================
    // bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // ==========================================================
    // register byte addresses
    localparam logic [7:0] OFS_CTRL  = 8'h00;  // pwm_shutdown_control
    localparam logic [7:0] OFS_STAT  = 8'h04;  // sticky event status, read only
    localparam logic [7:0] OFS_CLR   = 8'h08;  // event clear, write one to clear
    localparam logic [7:0] OFS_IEN   = 8'h0C;  // event interrupt enable
    localparam logic [7:0] OFS_CFG   = 8'h10;  // restart configuration

    // ==========================================================
    // pwm_shutdown_control fields
    localparam int unsigned CTRL_W       = 8;
    localparam int unsigned FLAG_BIT     = 7;  // shutdown_event_flag
    localparam int unsigned SRC_HI       = 6;  // fault_source_select
    localparam int unsigned SRC_LO       = 4;
    localparam int unsigned AC_HI        = 3;  // pair_ac_safe_state
    localparam int unsigned AC_LO        = 2;
    localparam int unsigned BD_HI        = 1;  // pair_bd_safe_state
    localparam int unsigned BD_LO        = 0;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;

    // fault source codes
    localparam logic [2:0] SRC_OFF      = 3'h0;
    localparam logic [2:0] SRC_CMP1     = 3'h1;
    localparam logic [2:0] SRC_CMP2     = 3'h2;
    localparam logic [2:0] SRC_CMP_ANY  = 3'h3;
    localparam logic [2:0] SRC_INT      = 3'h4;
    localparam logic [2:0] SRC_INT_CMP1 = 3'h5;
    localparam logic [2:0] SRC_INT_CMP2 = 3'h6;

    // ==========================================================
    // event status layout and other reset values
    localparam int unsigned EV_W        = 2;
    localparam int unsigned EV_SHUT     = 0;  // shutdown entered
    localparam int unsigned EV_RESUME   = 1;  // outputs resumed
    localparam logic [1:0]  EV_RESET    = 2'h0;
    localparam int unsigned CFG_AUTO    = 0;  // automatic restart enable
    localparam logic        CFG_RESET   = 1'h0;
    localparam int unsigned SYNC_W      = 3;  // int pin, comparator two, comparator one

endpackage

// *** hw/pas_sync.sv ***
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
`default_nettype none

module pas_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } pas_sync_s;

    pas_sync_s q;
    pas_sync_s d;

    // ==========================================================
    // per-bit chain; the first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_comb
            begin
                d.meta[i]   = async_in[i];
                d.stable[i] = q.meta[i];
            end
        end
    endgenerate

    // ==========================================================
    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '0;
        else
            q <= d;
    end

    assign sync_out = q.stable;

endmodule
`default_nettype wire

// *** hw/pas_top.sv ***
// pwm auto-shutdown block with apb register access
// Function
// - software writes to the shutdown flag are ignored while the fault persists
// - source 000 off, 001 comparator one, 010 comparator two, 011 either
// - source 100 int low, 101 int low or cmp one, 110 int low or cmp two
// - in shutdown a and c go low, high or high impedance per pair field
// - fault is a level; shutdown lasts while the selected level is present
// - after the flag clears, pwm resumes only at the next period start
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module pas_top (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [pas_pkg::ADDR_W-1:0] paddr,
    input  wire logic [pas_pkg::DATA_W-1:0] pwdata,
    output var  logic [pas_pkg::DATA_W-1:0] prdata,
    output var  logic                       pready,
    output var  logic                       pslverr,
    input  wire logic                       comparator_one,
    input  wire logic                       comparator_two,
    input  wire logic                       ext_int_n,
    input  wire logic                       pwm_in_a,
    input  wire logic                       pwm_in_b,
    input  wire logic                       pwm_in_c,
    input  wire logic                       pwm_in_d,
    input  wire logic                       pwm_period_start,
    output var  logic                       pwm_out_a,
    output var  logic                       pwm_out_b,
    output var  logic                       pwm_out_c,
    output var  logic                       pwm_out_d,
    output var  logic                       pwm_oe_a,
    output var  logic                       pwm_oe_b,
    output var  logic                       pwm_oe_c,
    output var  logic                       pwm_oe_d,
    output var  logic                       irq
);
    import pas_pkg::*;

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic              auto_rst;
        logic              shut;
        logic [EV_W-1:0]   ists;
        logic [EV_W-1:0]   ien;
        logic              irq;
        logic              pready;
        logic              pslverr;
        logic [DATA_W-1:0] prdata;
        logic [3:0]        out;
        logic [3:0]        oe;
    } pas_state_s;

    pas_state_s q;
    pas_state_s d;

    logic [SYNC_W-1:0] sync_s;
    logic              cmp1_s;
    logic              cmp2_s;
    logic              int_n_s;
    logic              fault;
    logic              setup;
    logic              acc;
    logic              flag_n;
    logic [EV_W-1:0]   ev;
    logic [1:0]        ac_f;
    logic [1:0]        bd_f;

    // ==========================================================
    // pin synchronisers
    pas_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .async_in({ext_int_n, comparator_two, comparator_one}),
        .sync_out(sync_s)
    );

    assign cmp1_s  = sync_s[0];
    assign cmp2_s  = sync_s[1];
    assign int_n_s = sync_s[2];

    // ==========================================================
    // fault source decode; level, never latched here
    always_comb
    begin
        unique case (q.ctrl[SRC_HI:SRC_LO])
            SRC_OFF:      fault = 1'b0;
            SRC_CMP1:     fault = cmp1_s;
            SRC_CMP2:     fault = cmp2_s;
            SRC_CMP_ANY:  fault = cmp1_s | cmp2_s;
            SRC_INT:      fault = !int_n_s;
            SRC_INT_CMP1: fault = !int_n_s | cmp1_s;
            SRC_INT_CMP2: fault = !int_n_s | cmp2_s;
            default:      fault = 1'b0;                  // unused code acts as off
        endcase
    end

    assign setup = psel && !penable;
    assign acc   = psel && penable && q.pready;

    // ==========================================================
    // next state: bus slave, flag, shutdown hold, events, pins
    always_comb
    begin
        d         = q;
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        flag_n    = q.ctrl[FLAG_BIT];
        ev        = EV_RESET;
        // no wait state: answer is prepared in the setup cycle
        if (setup)
        begin
            d.pready = 1'b1;
            d.prdata = '0;
            unique case (paddr)
                OFS_CTRL: d.prdata[CTRL_W-1:0] = q.ctrl;
                OFS_STAT: d.prdata[EV_W-1:0]   = q.ists;
                OFS_CLR:  d.prdata             = '0;
                OFS_IEN:  d.prdata[EV_W-1:0]   = q.ien;
                OFS_CFG:  d.prdata[CFG_AUTO]   = q.auto_rst;
                default:  d.pslverr            = 1'b1;
            endcase
        end
        // register writes take effect at the completing edge
        if (acc && pwrite && paddr == OFS_CTRL)
        begin
            d.ctrl[SRC_HI:0] = pwdata[SRC_HI:0];
            if (!fault)
                flag_n = pwdata[FLAG_BIT];
        end
        else if (q.auto_rst && !fault)
            flag_n = 1'b0;                               // automatic restart
        if (acc && pwrite && paddr == OFS_IEN)
            d.ien = pwdata[EV_W-1:0];
        if (acc && pwrite && paddr == OFS_CFG)
            d.auto_rst = pwdata[CFG_AUTO];
        // a present fault level wins over any clear
        if (fault)
            flag_n = 1'b1;
        d.ctrl[FLAG_BIT] = flag_n;
        // pair fields taken from the next control value, so pins follow a write at once
        ac_f = d.ctrl[AC_HI:AC_LO];
        bd_f = d.ctrl[BD_HI:BD_LO];
        // outputs stay safe until a period boundary after the flag drops
        if (flag_n)
            d.shut = 1'b1;
        else if (pwm_period_start)
            d.shut = 1'b0;
        ev[EV_SHUT]   = flag_n && !q.ctrl[FLAG_BIT];
        ev[EV_RESUME] = q.shut && !d.shut;
        // clear then set, so an event in the clear cycle survives
        d.ists = q.ists;
        if (acc && pwrite && paddr == OFS_CLR)
            d.ists = q.ists & ~pwdata[EV_W-1:0];
        d.ists = d.ists | ev;
        d.irq  = |(d.ists & d.ien);
        // pin drive: pair field bit 1 floats, else bit 0 is the level
        if (d.shut)
        begin
            d.oe[0]  = !ac_f[1];
            d.oe[2]  = !ac_f[1];
            d.out[0] = !ac_f[1] && ac_f[0];
            d.out[2] = !ac_f[1] && ac_f[0];
            d.oe[1]  = !bd_f[1];
            d.oe[3]  = !bd_f[1];
            d.out[1] = !bd_f[1] && bd_f[0];
            d.out[3] = !bd_f[1] && bd_f[0];
        end
        else
        begin
            d.oe  = 4'hF;
            d.out = {pwm_in_d, pwm_in_c, pwm_in_b, pwm_in_a};
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q          <= '0;
            q.ctrl     <= CTRL_RESET;
            q.auto_rst <= CFG_RESET;
            q.ists     <= EV_RESET;
            q.ien      <= EV_RESET;
        end
        else
            q <= d;
    end

    assign prdata    = q.prdata;
    assign pready    = q.pready;
    assign pslverr   = q.pslverr;
    assign irq       = q.irq;
    assign pwm_out_a = q.out[0];
    assign pwm_out_b = q.out[1];
    assign pwm_out_c = q.out[2];
    assign pwm_out_d = q.out[3];
    assign pwm_oe_a  = q.oe[0];
    assign pwm_oe_b  = q.oe[1];
    assign pwm_oe_c  = q.oe[2];
    assign pwm_oe_d  = q.oe[3];

    // ==========================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    flag_kept_a: assert property (fault && acc && pwrite && paddr == OFS_CTRL
        |=> q.ctrl[FLAG_BIT])
        else $error("flag cleared by write during fault");

    src_off_a: assert property (q.ctrl[SRC_HI:SRC_LO] == SRC_OFF |-> !fault)
        else $error("fault seen with source off");

    src_cmp_a: assert property (q.ctrl[SRC_HI:SRC_LO] == SRC_CMP_ANY
        |-> fault == (cmp1_s || cmp2_s))
        else $error("either comparator decode wrong");

    src_int_a: assert property (q.ctrl[SRC_HI:SRC_LO] == SRC_INT_CMP2
        |-> fault == (!int_n_s || cmp2_s))
        else $error("int or comparator two decode wrong");

    ac_safe_a: assert property (q.shut
        |-> (pwm_oe_a == !q.ctrl[AC_HI]) && (pwm_oe_c == !q.ctrl[AC_HI])
            && (pwm_out_a == (!q.ctrl[AC_HI] && q.ctrl[AC_LO])))
        else $error("pair a c not in safe state");

    bd_safe_a: assert property (q.shut
        |-> (pwm_oe_b == !q.ctrl[BD_HI]) && (pwm_oe_d == !q.ctrl[BD_HI])
            && (pwm_out_d == (!q.ctrl[BD_HI] && q.ctrl[BD_LO])))
        else $error("pair b d not in safe state");

    level_hold_a: assert property (fault [*2] |=> q.ctrl[FLAG_BIT] && q.shut)
        else $error("shutdown released while fault level present");

    resume_edge_a: assert property ($fell(q.shut)
        |-> $past(pwm_period_start) && !q.ctrl[FLAG_BIT])
        else $error("pwm resumed off a period boundary");

    flag_set_a: assert property (fault |=> q.ctrl[FLAG_BIT] && q.shut)
        else $error("fault did not raise flag and hold outputs");

    normal_run_a: assert property ($past(presetn) && !q.shut |-> pwm_oe_a && pwm_oe_b
        && pwm_oe_c && pwm_oe_d)
        else $error("outputs not driven in normal run");

    shut_cv: cover property ($rose(q.ctrl[FLAG_BIT]) ##[1:50] $fell(q.shut));
    wr_blk_cv: cover property (fault && acc && pwrite && paddr == OFS_CTRL);
    irq_cv: cover property ($rose(irq));

endmodule
`default_nettype wire

// *** tb/pas_power_stage.sv ***
// power stage model that resolves the four pwm pin levels
`timescale 1ns/10ps
`default_nettype none

module pas_power_stage (
    input  wire logic       pclk,
    input  wire logic [3:0] drv_lvl,
    input  wire logic [3:0] drv_en,
    output var  logic [3:0] pin_lvl
);
    // ==========================================================
    // released pins
    // no pull on these pins, so a released pin toggles each cycle
    // and does not hold the last driven level
    logic [3:0] float_q = 4'h5;

    always @(posedge pclk)
    begin
        float_q <= ~float_q;
    end

    // driven bits follow the driver, released ones float
    assign pin_lvl = (drv_lvl & drv_en) | (float_q & ~drv_en);
endmodule
`default_nettype wire

// *** tb/pwm_auto_shutdown_tb.sv ***
// self-checking bench for the pwm auto-shutdown block
`timescale 1ns/10ps
`default_nettype none

module pwm_auto_shutdown_tb;
    import pas_pkg::*;
    // ==========================================================
    // signals
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cmp1 = 1'b0;
    logic        cmp2 = 1'b0;
    logic        int_n = 1'b1;
    logic [3:0]  pwm_in = 4'h0;
    logic        per_start = 1'b0;
    logic [3:0]  out;
    logic [3:0]  oe;
    logic [3:0]  pin;
    logic        irq;
    logic [33:0] notes[$];
    logic [33:0] note;
    logic [2:0]  src;
    logic [1:0]  ac;
    logic [1:0]  bd;
    logic        hit;
    int          f;
    int          miscompares = 0;
    int          check_count = 0;
    int          seed = 32'h9966;

    pas_top i_pas_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .comparator_one(cmp1), .comparator_two(cmp2), .ext_int_n(int_n),
        .pwm_in_a(pwm_in[0]), .pwm_in_b(pwm_in[1]),
        .pwm_in_c(pwm_in[2]), .pwm_in_d(pwm_in[3]),
        .pwm_period_start(per_start),
        .pwm_out_a(out[0]), .pwm_out_b(out[1]),
        .pwm_out_c(out[2]), .pwm_out_d(out[3]),
        .pwm_oe_a(oe[0]), .pwm_oe_b(oe[1]), .pwm_oe_c(oe[2]), .pwm_oe_d(oe[3]),
        .irq(irq)
    );

    pas_power_stage i_pas_power_stage (
        .pclk(pclk), .drv_lvl(out), .drv_en(oe), .pin_lvl(pin)
    );

    // ==========================================================
    // helpers
    always #2.5 pclk = ~pclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one apb transfer; an idle edge after it keeps drivers single per step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic err);
        notes.push_back({~wr, err, d});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no cycle count assumed; only the watchdog ends a stuck wait
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // pin levels and enables, safe state or pass-through
    task automatic pins(input logic on);
        logic [3:0] en;
        logic [3:0] lv;
        en = on ? {~bd[1], ~ac[1], ~bd[1], ~ac[1]} : 4'hF;
        lv = on ? {bd == 2'b01, ac == 2'b01, bd == 2'b01, ac == 2'b01} : pwm_in;
        check(32'(oe), 32'(en));
        check(32'(pin & en), 32'(lv));
    endtask

    task automatic period_pulse();
        per_start <= 1'b1;
        @(posedge pclk);
        per_start <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    // response monitor: oldest note against each completed transfer
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            note = notes.pop_front();
            check(32'(pslverr), 32'(note[32]));
            if (note[33])
                check(prdata, note[31:0]);
        end
    end

    // ==========================================================
    // scenarios
    initial
    begin
        #200000;
        miscompares++;
        tally_and_finish();
    end

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, then an unmapped address
        for (int k = 0; k < 6; k++)
            apb(1'b0, 8'(k * 4), 32'h0, k == 5);
        // every source code against every single fault kind
        for (int i = 0; i < 21; i++)
        begin
            src = 3'(i / 3);
            f = i % 3;
            ac = 2'(i);
            bd = ~2'(i);
            hit = (f == 0) ? src inside {SRC_CMP1, SRC_CMP_ANY, SRC_INT_CMP1} :
                  (f == 1) ? src inside {SRC_CMP2, SRC_CMP_ANY, SRC_INT_CMP2} :
                             src inside {SRC_INT, SRC_INT_CMP1, SRC_INT_CMP2};
            pwm_in <= 4'($random(seed));
            apb(1'b1, OFS_CTRL, 32'({src, ac, bd}), 1'b0);
            cmp1 <= (f == 0);
            cmp2 <= (f == 1);
            int_n <= (f != 2);
            repeat (6) @(posedge pclk);
            pins(hit);
            apb(1'b1, OFS_CTRL, 32'({src, ac, bd}), 1'b0);
            apb(1'b0, OFS_CTRL, 32'({hit, src, ac, bd}), 1'b0);
            cmp1 <= 1'b0;
            cmp2 <= 1'b0;
            int_n <= 1'b1;
            repeat (6) @(posedge pclk);
            apb(1'b1, OFS_CTRL, 32'({src, ac, bd}), 1'b0);
            pins(hit);
            period_pulse();
            pins(1'b0);
        end
        // interrupt raised, masked and cleared
        apb(1'b1, OFS_CLR, 32'h3, 1'b0);
        apb(1'b1, OFS_IEN, 32'h1, 1'b0);
        apb(1'b1, OFS_CTRL, 32'({SRC_CMP1, 4'h0}), 1'b0);
        cmp1 <= 1'b1;
        repeat (6) @(posedge pclk);
        check(32'(irq), 32'h1);
        apb(1'b1, OFS_STAT, 32'h0, 1'b0);
        apb(1'b0, OFS_STAT, 32'h1, 1'b0);
        apb(1'b1, OFS_IEN, 32'h0, 1'b0);
        repeat (2) @(posedge pclk);
        check(32'(irq), 32'h0);
        cmp1 <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b1, OFS_CTRL, 32'({SRC_CMP1, 4'h0}), 1'b0);
        period_pulse();
        apb(1'b0, OFS_STAT, 32'h3, 1'b0);
        apb(1'b1, OFS_CLR, 32'h3, 1'b0);
        apb(1'b0, OFS_STAT, 32'h0, 1'b0);
        // automatic restart: flag drops by itself once the pin level is gone
        apb(1'b1, OFS_CFG, 32'h1, 1'b0);
        apb(1'b0, OFS_CFG, 32'h1, 1'b0);
        apb(1'b1, OFS_CTRL, 32'({SRC_INT, 4'h5}), 1'b0);
        ac = 2'h1;
        bd = 2'h1;
        int_n <= 1'b0;
        repeat (6) @(posedge pclk);
        pins(1'b1);
        int_n <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, OFS_CTRL, 32'({SRC_INT, 4'h5}), 1'b0);
        pins(1'b1);
        period_pulse();
        pins(1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
